// ---- pmrg_core_mem.sv ----
`timescale 1ns/100ps
module pmrg_core_mem
(
    input  wire logic [15:0] addr,
    output logic [7:0]       rdata
);
    // Never zero at the bench's addresses, so a blocked read stands out.
    assign rdata = addr[15:8] ^ addr[7:0] ^ 8'h5A;
endmodule : pmrg_core_mem

// ---- pmrg_guard.sv ----
`timescale 1ns/100ps
// Overview of operation
// RQ1: A 16-bit read limit splits code space into upper and lower partitions.
// RQ2: Lower is below the limit; upper includes the limit and above.
// RQ3: Table reads from upper into lower return zero.
// RQ4: Fetches from upper may still execute lower-partition code.
// RQ5: Table reads from lower return true data anywhere.
// RQ6: Limit is the security byte in the high byte, zero low byte.
// RQ7: Software should place the limit on a 512-byte boundary.
// RQ8: Unprogrammed security byte is zero, so everything is readable.
// RQ9: Erase enable plus a data write erases the whole addressed page.
// RQ10: Erase happens only when write enable is also set.
// RQ11: Write enable plus a data write programs one byte.
// RQ12: Software erases a location before programming it.
// RQ13: Upper six control bits read zero and ignore writes.
// RQ14: The read instruction's own program counter selects its partition.
module pmrg_guard
    import pmrg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    input  wire logic [7:0]  security_byte,
    input  wire logic        table_rd,
    input  wire logic [15:0] table_pc,
    input  wire logic [15:0] table_addr,
    input  wire logic [7:0]  mem_rdata,
    output logic [7:0]       table_rdata,
    output logic             table_valid,
    input  wire logic        fetch,
    input  wire logic [15:0] fetch_addr,
    output logic             fetch_ok,
    input  wire logic        dsm_wr,
    input  wire logic [15:0] dsm_addr,
    input  wire logic [7:0]  dsm_wdata,
    output logic             mem_prog,
    output logic             mem_erase,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    output logic [15:0]      read_limit_ff
);
    logic [1:0]  ctl_ff;
    logic [7:0]  sfr_rdata_ff;
    logic [7:0]  table_rdata_ff;
    logic        table_valid_ff;
    logic        fetch_ok_ff;
    logic        prog_ff;
    logic        erase_ff;
    logic [15:0] mem_addr_ff;
    logic [7:0]  mem_wdata_ff;
    logic [15:0] limit_ff;

    // Both partitions are judged against the same live security byte.
    wire         pc_upper; // RQ2
    wire         src_upper;
    wire [15:0]  limit_pc;
    wire         psc_hit   = (sfr_addr == PMRG_PSC_ADDR);
    wire         we_on     = ctl_ff[PMRG_PSC_WE_BIT];
    wire         pe_on     = ctl_ff[PMRG_PSC_PE_BIT];
    wire         blocked   = pc_upper && !src_upper; // RQ3 RQ5
    wire [7:0]   nxt_trd   = blocked ? PMRG_BLOCKED_DATA : mem_rdata; // RQ3
    wire [1:0]   nxt_ctl   = sfr_wdata[1:0]; // RQ13
    wire [7:0]   nxt_rdata = (sfr_rd && psc_hit) ? {6'h00, ctl_ff} : 8'h00;
    wire         do_erase  = dsm_wr && we_on && pe_on; // RQ9 RQ10
    wire         do_prog   = dsm_wr && we_on && !pe_on; // RQ11
    wire [6:0]   dsm_page  = dsm_addr[15:PMRG_PAGE_W];
    wire [15:0]  page_base = {dsm_page, {PMRG_PAGE_W{1'b0}}};
    wire [15:0]  nxt_maddr = do_erase ? page_base : dsm_addr; // RQ9

    // The security byte is assumed reset to zero by its owner when blank.
    pmrg_limit_cmp u_pc_cmp (
        .addr               (table_pc),           // RQ14
        .security_byte      (security_byte),
        .in_upper           (pc_upper),
        .read_limit_address (limit_pc)
    );
    pmrg_limit_cmp u_src_cmp (
        .addr               (table_addr),         // RQ2
        .security_byte      (security_byte),
        .in_upper           (src_upper),
        .read_limit_address ()
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctl_ff         <= PMRG_PSC_RESET[1:0];
            sfr_rdata_ff   <= 8'h00;
            table_rdata_ff <= 8'h00;
            table_valid_ff <= 1'b0;
            fetch_ok_ff    <= 1'b0;
            limit_ff       <= 16'h0000; // RQ8
        end else if (clk_en) begin
            if (sfr_wr && psc_hit)
                ctl_ff <= nxt_ctl;
            sfr_rdata_ff   <= nxt_rdata;
            table_rdata_ff <= table_rd ? nxt_trd : table_rdata_ff;
            table_valid_ff <= table_rd;
            fetch_ok_ff    <= fetch; // RQ4
            limit_ff       <= limit_pc; // RQ1
        end
    end

    // Erase takes precedence over program: the data byte is then don't care.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prog_ff      <= 1'b0;
            erase_ff     <= 1'b0;
            mem_addr_ff  <= 16'h0000;
            mem_wdata_ff <= 8'h00;
        end else if (clk_en) begin
            prog_ff      <= do_prog;
            erase_ff     <= do_erase;
            if (dsm_wr) begin
                mem_addr_ff  <= nxt_maddr;
                mem_wdata_ff <= dsm_wdata;
            end
        end
    end

    assign sfr_rdata     = sfr_rdata_ff;
    assign table_rdata   = table_rdata_ff;
    assign table_valid   = table_valid_ff;
    assign fetch_ok      = fetch_ok_ff;
    assign mem_prog      = prog_ff;
    assign mem_erase     = erase_ff;
    assign mem_addr      = mem_addr_ff;
    assign mem_wdata     = mem_wdata_ff;
    assign read_limit_ff = limit_ff;

    wire unused_fetch = ^fetch_addr;

    a_blocked_read_zero: assert property (@(posedge clk) disable iff (reset)
        clk_en && table_rd && blocked |=> table_valid && table_rdata == 8'h00)
        else $error("blocked table read returned data"); // RQ3
    a_lower_read_true: assert property (@(posedge clk) disable iff (reset)
        clk_en && table_rd && !pc_upper |=> table_rdata == $past(mem_rdata))
        else $error("lower partition read altered"); // RQ5
    a_erase_needs_we: assert property (@(posedge clk) disable iff (reset)
        mem_erase && $past(clk_en) |->
            $past(we_on) && $past(pe_on) && $past(dsm_wr))
        else $error("erase without both enables"); // RQ10
    a_erase_page_addr: assert property (@(posedge clk) disable iff (reset)
        mem_erase |-> mem_addr[8:0] == 9'h000)
        else $error("erase address not page aligned"); // RQ9
    a_prog_needs_we: assert property (@(posedge clk) disable iff (reset)
        mem_prog && $past(clk_en) |-> $past(we_on) && !mem_erase)
        else $error("program without write enable"); // RQ11
    a_ctl_upper_zero: assert property (@(posedge clk) disable iff (reset)
        sfr_rdata[7:2] == 6'h00)
        else $error("control upper bits not zero"); // RQ13
    a_limit_form: assert property (@(posedge clk) disable iff (reset)
        clk_en |=> read_limit_ff == {$past(security_byte), 8'h00})
        else $error("read limit misformed"); // RQ6
    a_fetch_allowed: assert property (@(posedge clk) disable iff (reset)
        clk_en && fetch |=> fetch_ok)
        else $error("fetch refused"); // RQ4

    // A control write is taken in one enabled cycle and shows the next.
    sequence s_ctl_write;
        clk_en && sfr_wr && psc_hit;
    endsequence

    sequence s_ctl_loaded;
        ctl_ff == $past(nxt_ctl);
    endsequence

    // A store request is taken in one cycle and answered in the next.
    sequence s_store_req;
        clk_en && dsm_wr && we_on;
    endsequence

    a_ctl_write_load: assert property (@(posedge clk) disable iff (reset)
        s_ctl_write |=> s_ctl_loaded)
        else $error("control write not loaded"); // RQ13

    a_ctl_read_back: assert property (@(posedge clk) disable iff (reset)
        clk_en && sfr_rd && psc_hit |=> sfr_rdata == {6'h00, $past(ctl_ff)})
        else $error("control read back wrong"); // RQ13

    // Freezing must hold the table data, both strobes and the read limit, not only the control bits.
    a_freeze_hold: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(ctl_ff) && $stable(table_rdata)
            && $stable(mem_prog) && $stable(mem_erase)
            && $stable(read_limit_ff))
        else $error("state moved while frozen");

    a_valid_pulse: assert property (@(posedge clk) disable iff (reset)
        clk_en && !table_rd |=> !table_valid)
        else $error("table valid without a read"); // RQ3

    a_upper_read_true: assert property (@(posedge clk) disable iff (reset)
        clk_en && table_rd && pc_upper && src_upper
            |=> table_rdata == $past(mem_rdata))
        else $error("upper partition read altered"); // RQ2

    a_prog_byte: assert property (@(posedge clk) disable iff (reset)
        s_store_req && !pe_on |=> mem_prog && !mem_erase
            && mem_addr == $past(dsm_addr)
            && mem_wdata == $past(dsm_wdata))
        else $error("byte program not issued"); // RQ11

    a_erase_page: assert property (@(posedge clk) disable iff (reset)
        s_store_req && pe_on |=> mem_erase && !mem_prog
            && mem_addr[15:9] == $past(dsm_page))
        else $error("page erase not issued"); // RQ9

    // Without write enable neither a program nor an erase strobe may reach the memory.
    a_store_locked: assert property (@(posedge clk) disable iff (reset)
        clk_en && dsm_wr && !we_on |=> !mem_prog && !mem_erase)
        else $error("store without write enable"); // RQ10
endmodule : pmrg_guard

// ---- pmrg_limit_cmp.sv ----
`timescale 1ns/100ps
module pmrg_limit_cmp
    import pmrg_pkg::*;
(
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  security_byte,
    output logic             in_upper,
    output logic [15:0]      read_limit_address
);
    assign read_limit_address = {security_byte, PMRG_LIMIT_LOW}; // RQ6
    assign in_upper           = (addr >= read_limit_address);   // RQ2
endmodule : pmrg_limit_cmp

// ---- pmrg_pkg.sv ----
package pmrg_pkg;
    localparam logic [7:0]  PMRG_PSC_ADDR      = 8'h8F;
    localparam logic [7:0]  PMRG_PSC_RESET     = 8'h00;
    localparam int          PMRG_PSC_WE_BIT    = 0;
    localparam int          PMRG_PSC_PE_BIT    = 1;
    localparam logic [7:0]  PMRG_SEC_RESET     = 8'h00;
    localparam logic [7:0]  PMRG_LIMIT_LOW     = 8'h00;
    localparam logic [7:0]  PMRG_BLOCKED_DATA  = 8'h00;
    localparam int          PMRG_ADDR_W        = 16;
    localparam int          PMRG_PAGE_W        = 9;
    typedef enum logic [1:0] {
        PMRG_OP_NONE,
        PMRG_OP_PROGRAM,
        PMRG_OP_ERASE
    } pmrg_op_e;
endpackage : pmrg_pkg

// ---- program_memory_read_guard_tb.sv ----
`timescale 1ns/100ps
module program_memory_read_guard_tb
    import pmrg_pkg::*;
;
logic        clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, table_rd = 0;
logic        clk_en = 1;
logic        fetch = 0, dsm_wr = 0, table_valid, fetch_ok, mem_prog, mem_erase;
logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata, security_byte = 0;
logic [7:0]  mem_rdata, table_rdata, dsm_wdata = 0, mem_wdata;
logic [15:0] table_pc = 0, table_addr = 0, fetch_addr = 0, dsm_addr = 0;
logic [15:0] mem_addr, read_limit_ff;
int          bad_count = 0, compares = 0, cycles = 0;
pmrg_guard i_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .security_byte(security_byte),
    .table_rd(table_rd), .table_pc(table_pc), .table_addr(table_addr),
    .mem_rdata(mem_rdata), .table_rdata(table_rdata),
    .table_valid(table_valid), .fetch(fetch), .fetch_addr(fetch_addr),
    .fetch_ok(fetch_ok), .dsm_wr(dsm_wr), .dsm_addr(dsm_addr),
    .dsm_wdata(dsm_wdata), .mem_prog(mem_prog), .mem_erase(mem_erase),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .read_limit_ff(read_limit_ff));
pmrg_core_mem i_mem (.addr(table_addr), .rdata(mem_rdata));
always #5 clk = ~clk;
always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
        bad_count++;
        report_and_stop();
    end
end
task report_and_stop();
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask : report_and_stop
task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
        bad_count++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
endtask : chk
task sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {wr, !wr, a, d};
    @(negedge clk) {sfr_wr, sfr_rd} = 2'b00;
endtask : sfr
task tread(input logic [15:0] pc, input logic [15:0] a, input logic [7:0] e);
    @(negedge clk) {table_rd, table_pc, table_addr} = {1'b1, pc, a};
    @(negedge clk) table_rd = 0;
    chk("table_valid", 16'h0001, {15'h0000, table_valid});
    chk("table_rdata", {8'h00, e}, {8'h00, table_rdata});
endtask : tread
task mwr(input logic [15:0] a, input logic p, input logic er,
         input logic [15:0] ea);
    @(negedge clk) {dsm_wr, dsm_addr, dsm_wdata} = {1'b1, a, 8'hA5};
    @(negedge clk) dsm_wr = 0;
    chk("mem_prog_erase", {14'h0000, p, er}, {14'h0000, mem_prog, mem_erase});
    if (p | er) chk("mem_addr", ea, mem_addr);
    if (p) chk("mem_wdata", 16'h00A5, {8'h00, mem_wdata});
endtask : mwr
task test_register();
    sfr(1'b0, PMRG_PSC_ADDR, 8'h00);
    chk("psc_reset", {8'h00, PMRG_PSC_RESET}, {8'h00, sfr_rdata});
    sfr(1'b1, PMRG_PSC_ADDR, 8'hFF);
    sfr(1'b0, PMRG_PSC_ADDR, 8'h00);
    chk("psc_bits", 16'h0003, {8'h00, sfr_rdata});
    sfr(1'b0, 8'h8E, 8'h00);
    chk("unmapped", 16'h0000, {8'h00, sfr_rdata});
endtask : test_register
task test_partition();
    @(negedge clk) security_byte = 8'h04;
    tread(16'h0400, 16'h03FF, 8'h00);
    chk("limit", 16'h0400, read_limit_ff);
    tread(16'h03FF, 16'h0000, 8'h5A);
    tread(16'h0400, 16'h0400, 8'h5E);
    tread(16'h0401, 16'h0000, 8'h00);
    @(negedge clk) security_byte = 8'h00;
    tread(16'hFF00, 16'h0000, 8'h5A);
endtask : test_partition
task test_store();
    sfr(1'b1, PMRG_PSC_ADDR, 8'h02);
    mwr(16'h0345, 1'b0, 1'b0, 16'h0000);
    sfr(1'b1, PMRG_PSC_ADDR, 8'h03);
    mwr(16'h0345, 1'b0, 1'b1, 16'h0200);
    sfr(1'b1, PMRG_PSC_ADDR, 8'h01);
    mwr(16'h0345, 1'b1, 1'b0, 16'h0345);
    sfr(1'b1, PMRG_PSC_ADDR, 8'h00);
    mwr(16'h0345, 1'b0, 1'b0, 16'h0000);
    @(negedge clk) {fetch, fetch_addr} = {1'b1, 16'h0000};
    @(negedge clk) fetch = 0;
    chk("fetch_ok", 16'h0001, {15'h0000, fetch_ok});
endtask : test_store
task test_freeze();
    @(negedge clk) clk_en = 0;
    sfr(1'b1, PMRG_PSC_ADDR, 8'h03);
    @(negedge clk) clk_en = 1;
    sfr(1'b0, PMRG_PSC_ADDR, 8'h00);
    chk("psc_frozen", 16'h0000, {8'h00, sfr_rdata});
endtask : test_freeze
initial begin
    repeat (6) @(negedge clk);
    reset = 0;
    test_register();
    test_partition();
    test_store();
    test_freeze();
    report_and_stop();
end
endmodule : program_memory_read_guard_tb
